/* rtl/wes_pkg.sv */
// Package for the wake enable and system-management status block.
// Assumes a single 200 MHz clock domain and a byte-wide register port.
package wes_pkg;

    localparam logic [7:0] OFF_WAKE_ENABLE_3 = 8'h07;
    localparam logic [7:0] OFF_SYSMGMT_STATUS_1 = 8'h08;
    localparam logic [7:0] OFF_SYSMGMT_STATUS_2 = 8'h09;
    localparam logic [7:0] OFF_SYSMGMT_ENABLE_1 = 8'h0A;
    localparam logic [7:0] OFF_SYSMGMT_ENABLE_2 = 8'h0B;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h21;

    localparam logic [7:0] RST_WAKE_ENABLE_3 = 8'h00;
    localparam logic [7:0] RST_SYSMGMT_STATUS_1 = 8'h00;
    localparam logic [7:0] RST_SYSMGMT_STATUS_2 = 8'h01;
    localparam logic [7:0] RST_SYSMGMT_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;

    // Writable / latching bit sets
    localparam logic [7:0] STS1_MASK = 8'hCE;
    localparam logic [7:0] STS2_LATCH_MASK = 8'h10;
    localparam int STS2_ALWAYS_ONE_BIT = 0;
    localparam int STS2_SERIAL2_BIT = 1;
    localparam int STS2_SERIAL1_BIT = 2;
    localparam int STS2_GPIO23_BIT = 4;

    // Interrupt status bit positions
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_SYSMGMT_BIT = 1;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h03;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wes_bus_req_t;

    typedef struct packed {
        logic [7:0] gpio3;
        logic [7:0] gpio1;
        logic gpio23;
    } wes_pins_t;

endpackage : wes_pkg

/* rtl/wes_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin inputs.
// Assumes pins are asynchronous to clock; output is a clean level.
`timescale 1ns/100ps
`default_nettype none

module wes_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } wes_sync_state_t;

    wes_sync_state_t state;
    wes_sync_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (clk_en)
        begin
            // First stage feeds only the second
            next_state.meta = din;
            next_state.stable = state.meta;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign dout = state.stable;

endmodule : wes_sync

`default_nettype wire

/* rtl/wes_top.sv */
// Wake enable 3 and system-management status 1/2 registers, wake output
// gating, grouped system-management signal and a software interrupt.
// Assumes wake status bits and global wake enable come from sibling logic
// on the same clock; pins and serial-port interrupts are asynchronous.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

// Contract
// - Wake asserts when enable, status, global all set
// - Disabled source still records status, no wake
// - Enable bit0 ring3 pin, bits1-7 pins 31-37
// - Enable 3 cleared only by standby power-on
// - Status 1 latches pins 11-13 and 16-17, write-one clears
// - Serial interrupt bits follow source, not writes
// - Status 2 bit4 latches pin 23, W1C
// - Status 2 bit0 reads one, never cleared
// - Bit0 set on power-ons and hard reset
// - Status reaches grouped signal only when enabled
module wes_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic standby_power_on_reset,
    input wire logic main_power_on_reset,
    input wire logic hard_reset,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] wake_status_3,
    input wire logic global_wake_enable,
    input wire logic gpio_pin_3_0_ring3,
    input wire logic [7:1] gpio_pin_3_x,
    input wire logic [7:0] gpio_pin_1_x,
    input wire logic gpio_pin_2_3,
    input wire logic serial_port1_irq_status,
    input wire logic serial_port2_irq_status,
    output logic wake_output_n,
    output logic grouped_sysmgmt_n,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0] wake_enable_3;
        logic [7:0] sysmgmt_status_1;
        logic [7:0] sysmgmt_status_2;
        logic [7:0] sysmgmt_enable_1;
        logic [7:0] sysmgmt_enable_2;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [7:0] pin1_prev;
        logic pin23_prev;
        logic [7:0] rdata;
        logic wake_n;
        logic smi_n;
        logic irq;
        logic wake_prev;
        logic smi_prev;
    } wes_state_t;

    wes_state_t state;
    wes_state_t next_state;

    wes_pkg::wes_bus_req_t bus;
    wes_pkg::wes_pins_t pins_raw;
    wes_pkg::wes_pins_t pins;
    logic [1:0] uart_sync;
    logic [7:0] sts2_view;
    logic wake_any;
    logic smi_any;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign pins_raw = '{gpio3: {gpio_pin_3_x, gpio_pin_3_0_ring3}, gpio1: gpio_pin_1_x, gpio23: gpio_pin_2_3};

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous inputs pass two flops before use

    wes_sync #(.WIDTH(19)) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .din({pins_raw, serial_port2_irq_status, serial_port1_irq_status}),
        .dout({pins, uart_sync})
    );

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] wes_w1c(input logic [7:0] cur, input logic [7:0] set,
                                           input logic [7:0] clr, input logic [7:0] msk);
        // Set beats clear so no event is lost in the clearing cycle
        wes_w1c = ((cur & ~clr) | set) & msk;
    endfunction : wes_w1c

    function automatic logic wes_hit(input wes_pkg::wes_bus_req_t b, input logic [7:0] off);
        wes_hit = b.wr && (b.addr == off);
    endfunction : wes_hit

    always_comb
    begin
        logic [7:0] pin1_rise;
        logic [7:0] clr1;
        logic [7:0] clr2;
        logic [7:0] irq_set;
        pin1_rise = 8'h00;
        clr1 = 8'h00;
        clr2 = 8'h00;
        irq_set = 8'h00;
        sts2_view = 8'h00;
        wake_any = 1'b0;
        smi_any = 1'b0;
        next_state = state;

        // Serial-port bits are live copies of their sources
        sts2_view = state.sysmgmt_status_2 & (wes_pkg::STS2_LATCH_MASK | 8'h01);
        sts2_view[wes_pkg::STS2_SERIAL2_BIT] = uart_sync[1];
        sts2_view[wes_pkg::STS2_SERIAL1_BIT] = uart_sync[0];

        // Pin 30/ring3 is bit 0, pins 31-37 are bits 1-7
        wake_any = |(state.wake_enable_3 & wake_status_3) & global_wake_enable;
        smi_any = |(state.sysmgmt_status_1 & state.sysmgmt_enable_1)
                  | |(sts2_view & state.sysmgmt_enable_2 & 8'h16);

        if (clk_en)
        begin
            pin1_rise = pins.gpio1 & ~state.pin1_prev;
            next_state.pin1_prev = pins.gpio1;
            next_state.pin23_prev = pins.gpio23;
            if (wes_hit(bus, wes_pkg::OFF_SYSMGMT_STATUS_1))
                clr1 = bus.wdata;
            if (wes_hit(bus, wes_pkg::OFF_SYSMGMT_STATUS_2))
                clr2 = bus.wdata & wes_pkg::STS2_LATCH_MASK;

            next_state.sysmgmt_status_1 = wes_w1c(state.sysmgmt_status_1, pin1_rise, clr1,
                                                  wes_pkg::STS1_MASK);
            next_state.sysmgmt_status_2 = wes_w1c(state.sysmgmt_status_2,
                                                  {3'h0, pins.gpio23 & ~state.pin23_prev, 4'h0},
                                                  clr2, wes_pkg::STS2_LATCH_MASK);
            next_state.sysmgmt_status_2[wes_pkg::STS2_ALWAYS_ONE_BIT] = 1'b1;

            if (wes_hit(bus, wes_pkg::OFF_WAKE_ENABLE_3))
                next_state.wake_enable_3 = bus.wdata;
            if (wes_hit(bus, wes_pkg::OFF_SYSMGMT_ENABLE_1))
                next_state.sysmgmt_enable_1 = bus.wdata & wes_pkg::STS1_MASK;
            if (wes_hit(bus, wes_pkg::OFF_SYSMGMT_ENABLE_2))
                next_state.sysmgmt_enable_2 = bus.wdata & 8'hD6;
            if (wes_hit(bus, wes_pkg::OFF_IRQ_MASK))
                next_state.irq_mask = bus.wdata & wes_pkg::IRQ_MASK_BITS;

            // Interrupt events are rising edges of wake and grouped signals
            irq_set[wes_pkg::IRQ_WAKE_BIT] = wake_any & ~state.wake_prev;
            irq_set[wes_pkg::IRQ_SYSMGMT_BIT] = smi_any & ~state.smi_prev;
            next_state.wake_prev = wake_any;
            next_state.smi_prev = smi_any;
            next_state.irq_status = wes_w1c(state.irq_status, irq_set,
                                            wes_hit(bus, wes_pkg::OFF_IRQ_STATUS) ? bus.wdata : 8'h00,
                                            wes_pkg::IRQ_MASK_BITS);

            next_state.wake_n = ~wake_any;
            next_state.smi_n = ~smi_any;
            // A set mask bit blocks its source; mask resets open
            next_state.irq = |(next_state.irq_status & ~state.irq_mask);

            next_state.rdata = 8'h00;
            if (bus.rd)
            begin
                unique case (bus.addr)
                    wes_pkg::OFF_WAKE_ENABLE_3: next_state.rdata = state.wake_enable_3;
                    wes_pkg::OFF_SYSMGMT_STATUS_1: next_state.rdata = state.sysmgmt_status_1;
                    wes_pkg::OFF_SYSMGMT_STATUS_2: next_state.rdata = sts2_view;
                    wes_pkg::OFF_SYSMGMT_ENABLE_1: next_state.rdata = state.sysmgmt_enable_1;
                    wes_pkg::OFF_SYSMGMT_ENABLE_2: next_state.rdata = state.sysmgmt_enable_2;
                    wes_pkg::OFF_IRQ_STATUS: next_state.rdata = state.irq_status;
                    wes_pkg::OFF_IRQ_MASK: next_state.rdata = state.irq_mask;
                    default: next_state.rdata = 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only standby power-on clears the enables; rst alone keeps them so that
    // a main-supply or soft/hard reset mapped onto rst cannot lose wake setup.

    always_ff @(posedge clock)
    begin
        if (standby_power_on_reset)
        begin
            state <= '0;
            state.wake_enable_3 <= wes_pkg::RST_WAKE_ENABLE_3;
            state.sysmgmt_status_1 <= wes_pkg::RST_SYSMGMT_STATUS_1;
            state.sysmgmt_status_2 <= wes_pkg::RST_SYSMGMT_STATUS_2;
            state.sysmgmt_enable_1 <= wes_pkg::RST_SYSMGMT_ENABLE;
            state.sysmgmt_enable_2 <= wes_pkg::RST_SYSMGMT_ENABLE;
            state.irq_status <= wes_pkg::RST_IRQ;
            state.irq_mask <= wes_pkg::RST_IRQ;
            state.wake_n <= 1'b1;
            state.smi_n <= 1'b1;
        end
        else if (rst)
        begin
            state.rdata <= 8'h00;
            state.irq <= 1'b0;
            state.wake_n <= 1'b1;
            state.smi_n <= 1'b1;
            state.wake_prev <= 1'b0;
            state.smi_prev <= 1'b0;
            state.pin1_prev <= 8'h00;
            state.pin23_prev <= 1'b0;
            state.irq_status <= wes_pkg::RST_IRQ;
            state.sysmgmt_status_2 <= state.sysmgmt_status_2 | wes_pkg::RST_SYSMGMT_STATUS_2;
        end
        else if (main_power_on_reset || hard_reset)
        begin
            state <= next_state;
            state.sysmgmt_status_2[wes_pkg::STS2_ALWAYS_ONE_BIT] <= 1'b1;
        end
        else
            state <= next_state;
    end

    assign reg_rdata = state.rdata;
    assign wake_output_n = state.wake_n;
    assign grouped_sysmgmt_n = state.smi_n;
    assign irq = state.irq;

endmodule : wes_top

`default_nettype wire

/* tb/wes_host_model.sv */
// Host side model: latches wake and grouped signal assertions.
// Assumes both inputs are active low levels from wes_top.
`timescale 1ns/100ps
`default_nettype none
module wes_host_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic wake_output_n,
    input wire logic grouped_sysmgmt_n,
    output logic wake_seen,
    output logic smi_seen
);
    // Sticky so the bench can look after a short pulse is gone
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wake_seen <= 1'b0;
            smi_seen <= 1'b0;
        end
        else
        begin
            wake_seen <= wake_seen | ~wake_output_n;
            smi_seen <= smi_seen | ~grouped_sysmgmt_n;
        end
    end
endmodule : wes_host_model
`default_nettype wire

/* tb/wes_top_chk.sv */
// Checker for wes_top outputs and register reads.
// Assumes one clock domain; bound into every wes_top.
`timescale 1ns/100ps
`default_nettype none
module wes_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic standby_power_on_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] wake_status_3,
    input wire logic global_wake_enable,
    input wire logic serial_port1_irq_status,
    input wire logic serial_port2_irq_status,
    input wire logic wake_output_n,
    input wire logic grouped_sysmgmt_n,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire logic rdv = reg_rd & clk_en;
    wire logic rd08 = rdv && reg_addr == 8'h08;
    wire logic rd09 = rdv && reg_addr == 8'h09;
    wire logic rdun = rdv && !(reg_addr inside {8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h20, 8'h21});
    ////////////////////////////////////////////////////////////////////////////////
    chk_wake_global: assert property ((!global_wake_enable) [*3] |-> wake_output_n)
        else $error("wake low without global enable");
    chk_wake_idle: assert property ((wake_status_3 == 8'h00) [*3] |-> wake_output_n)
        else $error("wake low without status");
    chk_rdata_idle: assert property (!rdv |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_sts2_one: assert property (rd09 |=> reg_rdata[0])
        else $error("status 2 bit 0 reads zero");
    chk_sts2_rsvd: assert property (rd09 |=> (reg_rdata & 8'hE8) == 8'h00)
        else $error("status 2 reserved bits set");
    chk_sts1_rsvd: assert property (rd08 |=> (reg_rdata & 8'h31) == 8'h00)
        else $error("status 1 reserved bits set");
    chk_serial1_live: assert property (serial_port1_irq_status [*4] ##0 rd09 |=> reg_rdata[2])
        else $error("serial 1 bit not following source");
    chk_serial2_live: assert property (!serial_port2_irq_status [*4] ##0 rd09 |=> !reg_rdata[1])
        else $error("serial 2 bit not following source");
    chk_unmapped_zero: assert property (rdun |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_standby_out: assert property (standby_power_on_reset |=> wake_output_n && grouped_sysmgmt_n && !irq)
        else $error("outputs active after standby reset");
    cover property (!wake_output_n);
    cover property (!grouped_sysmgmt_n);
    cover property (irq);
endmodule : wes_chk
bind wes_top wes_chk u_chk (.clock, .rst, .clk_en, .standby_power_on_reset, .reg_addr, .reg_rd, .reg_rdata,
    .wake_status_3, .global_wake_enable, .serial_port1_irq_status, .serial_port2_irq_status, .wake_output_n,
    .grouped_sysmgmt_n, .irq);
`default_nettype wire

/* tb/wes_top_tb.sv */
// Self-checking bench for wes_top: wake gating table, then hand tests.
// Assumes wes_host_model and the bound checker compile beside it.
`timescale 1ns/100ps
`default_nettype none
module wes_top_tb;
    typedef struct packed {logic [7:0] en; logic [7:0] sts; logic glob; logic wn;} wes_row_t;
    wes_row_t rows [6] = '{'{8'hFF, 8'h01, 1'b1, 1'b0}, '{8'h00, 8'hFF, 1'b1, 1'b1}, '{8'hFF, 8'hFF, 1'b0, 1'b1},
        '{8'h02, 8'h01, 1'b1, 1'b1}, '{8'h80, 8'h80, 1'b1, 1'b0}, '{8'h7F, 8'h80, 1'b1, 1'b1}};
    logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, standby_power_on_reset = 1'b1, main_power_on_reset = 1'b0;
    logic hard_reset = 1'b0, soft_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, global_wake_enable = 1'b0;
    logic gpio_pin_2_3 = 1'b0, serial_port1_irq_status = 1'b0, serial_port2_irq_status = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, wake_status_3 = 8'h00, gpio_pin_1_x = 8'h00, reg_rdata;
    logic wake_output_n, grouped_sysmgmt_n, irq, wake_seen, smi_seen;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2.5 clock = ~clock;
    wes_top u_dut (.clock, .rst, .clk_en, .standby_power_on_reset, .main_power_on_reset, .hard_reset, .soft_reset,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_status_3, .global_wake_enable,
        .gpio_pin_3_0_ring3(1'b0), .gpio_pin_3_x(7'h00), .gpio_pin_1_x, .gpio_pin_2_3, .serial_port1_irq_status,
        .serial_port2_irq_status, .wake_output_n, .grouped_sysmgmt_n, .irq);
    wes_host_model u_host (.clock, .rst, .wake_output_n, .grouped_sysmgmt_n, .wake_seen, .smi_seen);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask : rd
    // Pins pass two sync flops and an edge stage, so allow slack
    task automatic pause(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : pause
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        standby_power_on_reset <= 1'b0;
        rd(8'h07, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h01);
        rd(8'h55, 8'h00);
        $display("reset values done");
        foreach (rows[i])
        begin
            wr(8'h07, rows[i].en);
            wake_status_3 <= rows[i].sts;
            global_wake_enable <= rows[i].glob;
            pause(4);
            chk("wake_output_n", {7'h00, wake_output_n}, {7'h00, rows[i].wn});
        end
        chk("wake_seen", {7'h00, wake_seen}, 8'h01);
        $display("wake table done");
        wr(8'h07, 8'h5A);
        {rst, main_power_on_reset, hard_reset, soft_reset} <= 4'hF;
        repeat (2) @(posedge clock);
        {rst, main_power_on_reset, hard_reset, soft_reset} <= 4'h0;
        rd(8'h07, 8'h5A);
        rd(8'h09, 8'h01);
        @(posedge clock);
        {main_power_on_reset, hard_reset, soft_reset} <= 3'h7;
        repeat (2) @(posedge clock);
        {main_power_on_reset, hard_reset, soft_reset} <= 3'h0;
        rd(8'h07, 8'h5A);
        rd(8'h09, 8'h01);
        @(posedge clock);
        standby_power_on_reset <= 1'b1;
        @(posedge clock);
        standby_power_on_reset <= 1'b0;
        rd(8'h07, 8'h00);
        $display("reset kinds done");
        wr(8'h20, 8'hFF);
        gpio_pin_1_x <= 8'hFF;
        pause(6);
        chk("grouped_sysmgmt_n", {7'h00, grouped_sysmgmt_n}, 8'h01);
        rd(8'h08, 8'hCE);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'hCE);
        wr(8'h0A, 8'h02);
        pause(3);
        chk("grouped_sysmgmt_n", {7'h00, grouped_sysmgmt_n}, 8'h00);
        chk("smi_seen", {7'h00, smi_seen}, 8'h01);
        rd(8'h20, 8'h02);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(8'h21, 8'h03);
        pause(2);
        chk("irq", {7'h00, irq}, 8'h00);
        wr(8'h08, 8'h42);
        rd(8'h08, 8'h8C);
        wr(8'h08, 8'hFF);
        pause(3);
        chk("grouped_sysmgmt_n", {7'h00, grouped_sysmgmt_n}, 8'h01);
        wr(8'h20, 8'h02);
        rd(8'h20, 8'h00);
        $display("status 1 and interrupt done");
        @(posedge clock);
        {gpio_pin_2_3, serial_port1_irq_status, serial_port2_irq_status} <= 3'h7;
        pause(6);
        rd(8'h09, 8'h17);
        wr(8'h0B, 8'h04);
        pause(3);
        chk("grouped_sysmgmt_n", {7'h00, grouped_sysmgmt_n}, 8'h00);
        rd(8'h0B, 8'h04);
        wr(8'h09, 8'hFF);
        rd(8'h09, 8'h07);
        @(posedge clock);
        {serial_port1_irq_status, serial_port2_irq_status} <= 2'h0;
        pause(6);
        rd(8'h09, 8'h01);
        chk("grouped_sysmgmt_n", {7'h00, grouped_sysmgmt_n}, 8'h01);
        $display("status 2 done");
        // Pin pulse and write while frozen must leave no trace
        @(posedge clock);
        clk_en <= 1'b0;
        gpio_pin_1_x <= 8'h00;
        pause(4);
        wr(8'h07, 8'hFF);
        @(posedge clock);
        gpio_pin_1_x <= 8'hFF;
        clk_en <= 1'b1;
        pause(4);
        rd(8'h08, 8'h00);
        rd(8'h07, 8'h00);
        $display("clock enable done");
        results();
    end
endmodule : wes_top_tb
`default_nettype wire
